/* File: verilog/sacr_pkg.sv */
package sacr_pkg;
	// node addressing
	localparam logic [5:0] ADDR_ZERO = 6'h00;
	localparam logic [5:0] ADDR_BCAST = 6'h3f;
	// register offsets
	localparam logic [7:0] OFF_DEV_STATUS = 8'h00;
	localparam logic [7:0] OFF_ALERT_STATUS = 8'h20;
	localparam logic [7:0] OFF_FAULT_STATUS = 8'h21;
	localparam logic [7:0] OFF_GATE = 8'h3a;
	localparam logic [7:0] OFF_ADDR_CTRL = 8'h3b;
	localparam logic [7:0] OFF_RESET = 8'h3c;
	localparam logic [7:0] OFF_BURN = 8'h3f;
	localparam logic [7:0] OFF_CFG_BASE = 8'h40;
	// command values
	localparam logic [7:0] GATE_UNLOCK = 8'h35;
	localparam logic [7:0] GATE_RELOAD = 8'h27;
	localparam logic [7:0] RESET_CMD = 8'ha5;
	localparam logic [7:0] BURN_CMD = 8'h91;
	// values after reset
	localparam logic [7:0] ALERT_RST = 8'h80;
	localparam logic [7:0] FAULT_RST = 8'h08;
	// field positions
	localparam int DS_AR = 6;
	localparam int DS_ALERT = 5;
	localparam int DS_FAULT = 4;
	localparam int DS_CORRECTED_ERROR_FLAG = 3;
	localparam int AS_ADDR_REQ = 7;
	localparam int AS_PARITY = 6;
	localparam int AS_ECC_ERR = 5;
	localparam int AS_I_FAULT = 4;
	localparam int FS_CRC = 0;
	localparam int AC_AR = 7;
	localparam int IO_CFG_IDX = 1;
	localparam int IO_CRC_DIS = 0;
	// protected register set and its otp word
	localparam int CFG_COUNT = 12;
	localparam int CFG_WRITABLE = 8;
	localparam int OTP_W = 13;
	localparam logic [11:0] HAM_M1 = 12'h555;
	localparam logic [11:0] HAM_M2 = 12'h666;
	localparam logic [11:0] HAM_M4 = 12'h878;
	localparam logic [11:0] HAM_M8 = 12'hf80;
	localparam logic [7:0] CRC_POLY = 8'h07;
	// packet lengths in whole bytes
	localparam logic [2:0] WR_BYTES_CRC = 3'h4;
	localparam logic [2:0] WR_BYTES_NOCRC = 3'h3;
	// synchroniser lanes
	localparam int SY_CS = 0;
	localparam int SY_SCLK = 1;
	localparam int SY_SDI = 2;
	localparam int SY_SDO = 3;
	localparam int SY_ALERT = 4;
	localparam int SY_PROG = 5;
	localparam int SY_N = 6;

	typedef enum logic [1:0] {
		PK_IDLE = 2'b00,
		PK_RECV = 2'b01,
		PK_READ = 2'b10,
		PK_SKIP = 2'b11
	} sacr_pk_t;
endpackage

/* File: verilog/sacr_crc8.sv */
`timescale 1ns/1ps
`default_nettype none
module sacr_crc8
	import sacr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_clear,
	input wire logic i_bit_en,
	input wire logic i_bit,
	output logic [7:0] o_crc
);
	logic [7:0] crc;
	logic [7:0] next_crc;

	// bit serial, msb first; running it over the trailing crc byte leaves zero
	assign next_crc = {crc[6:0], 1'b0} ^ ((crc[7] ^ i_bit) ? CRC_POLY : 8'h00);
	assign o_crc = crc;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			crc <= 8'h00;
		end else if (i_clear) begin
			crc <= 8'h00;
		end else if (i_bit_en) begin
			crc <= next_crc;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/sacr_node.sv */
`timescale 1ns/1ps
`default_nettype none
module sacr_node
	import sacr_pkg::*;
#(
	parameter int CFG_N = CFG_COUNT,
	parameter int CFG_WR = CFG_WRITABLE,
	localparam int OTP_BITS = CFG_N * OTP_W,
	localparam int SEL_W = $clog2(OTP_BITS)
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_cs_south,
	input wire logic i_sclk_south,
	input wire logic i_sdi_south,
	output logic o_sdo_south,
	output logic o_cs_north,
	output logic o_sclk_north,
	output logic o_sdi_north,
	input wire logic i_sdo_north,
	input wire logic i_alert_north,
	output logic o_alert_south,
	output logic o_fault,
	input wire logic i_prog_supply,
	input wire logic i_otp_upset,
	input wire logic [SEL_W-1:0] i_otp_upset_sel,
	output logic [5:0] o_node_addr,
	output logic o_addr_assigned
);
	function automatic logic [12:0] ham_enc(input logic [7:0] d);
		logic [11:0] c;
		c = {d[7:4], 1'b0, d[3:1], 1'b0, d[0], 2'b00};
		c[0] = ^(c & HAM_M1);
		c[1] = ^(c & HAM_M2);
		c[3] = ^(c & HAM_M4);
		c[7] = ^(c & HAM_M8);
		return {^c, c};
	endfunction

	// returns {uncorrectable, corrected, data}
	function automatic logic [9:0] ham_dec(input logic [12:0] w);
		logic [11:0] c;
		logic [3:0] s;
		logic ov;
		logic err;
		c = w[11:0];
		s = {^(c & HAM_M8), ^(c & HAM_M4), ^(c & HAM_M2), ^(c & HAM_M1)};
		ov = ^w;
		err = ((s != 4'h0) && !ov) || (ov && (s > 4'hc));
		if (ov && !err && (s != 4'h0))
			c = c ^ (12'h001 << (s - 4'h1));
		return {err, ov && !err, c[11:8], c[6:4], c[2]};
	endfunction

	// pin synchronisers: stage one feeds stage two only
	logic [SY_N-1:0] sy1;
	logic [SY_N-1:0] sy2;
	logic [SY_N-1:0] sy3;

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sy1 <= '0;
			sy2 <= '0;
			sy3 <= '0;
		end else begin
			sy1 <= {i_prog_supply, i_alert_north, i_sdo_north, i_sdi_south, i_sclk_south, i_cs_south};
			sy2 <= sy1;
			sy3 <= sy2;
		end
	end

	wire cs_rise = sy2[SY_CS] & ~sy3[SY_CS];
	wire cs_fall = ~sy2[SY_CS] & sy3[SY_CS];
	wire sclk_rise = sy2[SY_SCLK] & ~sy3[SY_SCLK];

	sacr_pk_t state;
	logic [2:0] bitcnt;
	logic [2:0] bytecnt;
	logic [6:0] rx;
	logic [7:0] hdr_addr;
	logic [7:0] hdr_off;
	logic [7:0] hdr_data;
	logic [7:0] shreg;
	logic [7:0] rd_ptr;
	logic [7:0] rd_byte;
	logic [7:0] crc;

	logic [5:0] node_addr;
	logic addr_assigned;
	logic [7:0] alert_status;
	logic [7:0] fault_status;
	logic [7:0] gate;
	logic unlock;
	logic corrected_error_flag;
	logic soft_rst;
	logic load_pending;
	logic [OTP_BITS-1:0] otp_mem;
	logic [CFG_N*8-1:0] cfg_flat;
	logic [CFG_N*8-1:0] dec_flat;
	logic [OTP_BITS-1:0] burn_vec;
	logic [CFG_N-1:0] cor_vec;
	logic [CFG_N-1:0] err_vec;
	logic [CFG_N-1:0] par_bad;
	logic [7:0] next_alert;
	logic [7:0] next_fault;

	wire [7:0] next_byte = {rx, sy2[SY_SDI]};
	wire byte_done = sclk_rise && (bitcnt == 3'h7);
	// only writes may use the broadcast address; two readers would collide
	wire accept = !next_byte[7] && ((next_byte[6:1] == node_addr) ||
		(next_byte[0] && (next_byte[6:1] == ADDR_BCAST)));
	wire crc_en = !cfg_flat[IO_CFG_IDX*8 + IO_CRC_DIS];
	wire pkt_end = cs_fall && (state == PK_RECV) && hdr_addr[0];
	wire crc_ok = crc_en ? ((bytecnt == WR_BYTES_CRC) && (bitcnt == 3'h0) && (crc == 8'h00))
		: (bytecnt >= WR_BYTES_NOCRC);
	wire wr_fire = pkt_end && crc_ok;
	wire crc_fail = pkt_end && crc_en && !crc_ok;
	wire [7:0] rd_sel = (state == PK_RECV) ? hdr_off : rd_ptr;
	wire [7:0] cfg_rd_idx = rd_sel - OFF_CFG_BASE;
	wire wr_addr = wr_fire && (hdr_off == OFF_ADDR_CTRL);
	wire wr_alert = wr_fire && (hdr_off == OFF_ALERT_STATUS);
	wire wr_fault = wr_fire && (hdr_off == OFF_FAULT_STATUS);
	wire wr_gate = wr_fire && (hdr_off == OFF_GATE);
	wire wr_reset = wr_fire && (hdr_off == OFF_RESET) && (hdr_data == RESET_CMD);
	wire otp_burned = |otp_mem;
	wire do_burn = wr_fire && (hdr_off == OFF_BURN) && (hdr_data == BURN_CMD) &&
		sy2[SY_PROG] && !otp_burned;
	wire any_cor = |cor_vec;
	wire any_err = |err_vec;
	wire [OTP_BITS-1:0] upset_mask = i_otp_upset ? (OTP_BITS'(1) << i_otp_upset_sel) : '0;
	wire [7:0] dev_status = (8'(addr_assigned) << DS_AR) | (8'(|alert_status) << DS_ALERT) |
		(8'(|fault_status) << DS_FAULT) | (8'(corrected_error_flag) << DS_CORRECTED_ERROR_FLAG);

	sacr_crc8 u_crc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_clear(cs_rise),
		.i_bit_en(sclk_rise && (state == PK_RECV)),
		.i_bit(sy2[SY_SDI]),
		.o_crc(crc)
	);

	// unmapped and write-only offsets read as zero
	always_comb begin
		rd_byte = 8'h00;
		case (rd_sel)
			OFF_DEV_STATUS: rd_byte = dev_status;
			OFF_ALERT_STATUS: rd_byte = alert_status;
			OFF_FAULT_STATUS: rd_byte = fault_status;
			OFF_GATE: rd_byte = gate;
			OFF_ADDR_CTRL: rd_byte = {addr_assigned, 1'b0, node_addr};
			default: begin
				if (cfg_rd_idx < 8'(CFG_N))
					rd_byte = cfg_flat[cfg_rd_idx*8 +: 8];
			end
		endcase
	end

	// packet receiver; a read's length byte lands in hdr_data unused, reads run until chip-select drops
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= PK_IDLE;
			bitcnt <= 3'h0;
			bytecnt <= 3'h0;
			rx <= 7'h00;
			hdr_addr <= 8'h00;
			hdr_off <= 8'h00;
			hdr_data <= 8'h00;
			shreg <= 8'h00;
			rd_ptr <= 8'h00;
		end else if (cs_rise) begin
			state <= PK_RECV;
			bitcnt <= 3'h0;
			bytecnt <= 3'h0;
			hdr_addr <= 8'h00;
		end else if (cs_fall) begin
			state <= PK_IDLE;
		end else if (sclk_rise && (state != PK_IDLE)) begin
			rx <= next_byte[6:0];
			bitcnt <= bitcnt + 3'h1;
			if (byte_done && (bytecnt != 3'h7))
				bytecnt <= bytecnt + 3'h1;
			case (state)
				PK_RECV: begin
					if (byte_done && (bytecnt == 3'h0)) begin
						hdr_addr <= next_byte;
						if (!accept)
							state <= PK_SKIP;
					end
					if (byte_done && (bytecnt == 3'h1))
						hdr_off <= next_byte;
					if (byte_done && (bytecnt == 3'h2)) begin
						hdr_data <= next_byte;
						if (!hdr_addr[0]) begin
							state <= PK_READ;
							shreg <= rd_byte;
							rd_ptr <= hdr_off + 8'h01;
						end
					end
				end
				PK_READ: begin
					if (byte_done) begin
						shreg <= rd_byte;
						rd_ptr <= rd_ptr + 8'h01;
					end else begin
						shreg <= {shreg[6:0], 1'b0};
					end
				end
				default: begin
				end
			endcase
		end
	end

	// relay toward the next node; only a valid address lets selection pass north
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_cs_north <= 1'b0;
			o_sclk_north <= 1'b0;
			o_sdi_north <= 1'b0;
			o_sdo_south <= 1'b0;
		end else begin
			o_cs_north <= sy2[SY_CS] && (node_addr != ADDR_ZERO);
			o_sclk_north <= sy2[SY_SCLK];
			o_sdi_north <= sy2[SY_SDI];
			o_sdo_south <= (state == PK_READ) ? shreg[7] : sy2[SY_SDO];
		end
	end

	// status flags: a hardware set in the same cycle as a host clear wins
	always_comb begin
		next_alert = alert_status;
		if (wr_alert)
			next_alert = next_alert & ~(hdr_data & ~(8'h01 << AS_ADDR_REQ));
		if (wr_addr)
			next_alert[AS_ADDR_REQ] = 1'b0;
		if (|par_bad)
			next_alert[AS_PARITY] = 1'b1;
		if (load_pending && any_err) begin
			next_alert[AS_ECC_ERR] = 1'b1;
			next_alert[AS_I_FAULT] = 1'b1;
		end
		next_fault = fault_status;
		if (wr_fault)
			next_fault = next_fault & ~hdr_data;
		if (crc_fail)
			next_fault[FS_CRC] = 1'b1;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			alert_status <= ALERT_RST;
			fault_status <= FAULT_RST;
			node_addr <= ADDR_ZERO;
			addr_assigned <= 1'b0;
		end else if (soft_rst) begin
			alert_status <= ALERT_RST;
			fault_status <= FAULT_RST;
			node_addr <= ADDR_ZERO;
			addr_assigned <= 1'b0;
		end else begin
			alert_status <= next_alert;
			fault_status <= next_fault;
			if (wr_addr) begin
				node_addr <= hdr_data[5:0];
				addr_assigned <= 1'b1;
			end
		end
	end

	// gate, unlock and load sequencing
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			gate <= 8'h00;
			unlock <= 1'b0;
			soft_rst <= 1'b0;
			load_pending <= 1'b1;
			corrected_error_flag <= 1'b0;
		end else begin
			soft_rst <= wr_reset;
			load_pending <= soft_rst || (wr_gate && (hdr_data == GATE_RELOAD));
			if (soft_rst) begin
				gate <= 8'h00;
				unlock <= 1'b0;
			end else if (wr_fire) begin
				if (wr_gate)
					gate <= hdr_data;
				unlock <= wr_gate && (hdr_data == GATE_UNLOCK);
			end
			if (soft_rst)
				corrected_error_flag <= 1'b0;
			else if (load_pending && any_cor)
				corrected_error_flag <= 1'b1;
		end
	end

	// otp array starts unprogrammed; the upset input models a disturbed cell
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			otp_mem <= '0;
		else
			otp_mem <= (otp_mem | burn_vec) ^ upset_mask;
	end

	genvar gi;
	generate
		for (gi = 0; gi < CFG_N; gi = gi + 1) begin : g_cfg
			logic [7:0] val;
			logic par;
			logic [9:0] dec;
			assign dec = ham_dec(otp_mem[gi*OTP_W +: OTP_W]);
			assign cor_vec[gi] = dec[8];
			assign err_vec[gi] = dec[9];
			assign dec_flat[gi*8 +: 8] = dec[7:0];
			assign cfg_flat[gi*8 +: 8] = val;
			assign par_bad[gi] = par ^ (^val);
			assign burn_vec[gi*OTP_W +: OTP_W] = do_burn ? ham_enc(val) : '0;
			wire wr_me = wr_fire && unlock && (gi < CFG_WR) &&
				(hdr_off == OFF_CFG_BASE + 8'(gi));
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					val <= 8'h00;
					par <= 1'b0;
				end else if (load_pending) begin
					val <= dec[7:0];
					par <= ^dec[7:0];
				end else if (wr_me) begin
					val <= hdr_data;
					par <= ^hdr_data;
				end
			end
		end
	endgenerate

	assign o_alert_south = (|alert_status) || sy2[SY_ALERT];
	assign o_fault = fault_status[FS_CRC];
	assign o_node_addr = node_addr;
	assign o_addr_assigned = addr_assigned;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	a_zero_blocks_cs: assert property ((node_addr == ADDR_ZERO) |=> !o_cs_north)
		else $error("chip-select passed north at address zero");
	a_cs_follows: assert property ((node_addr != ADDR_ZERO) && sy2[SY_CS] |=> o_cs_north)
		else $error("chip-select not relayed north");
	a_reset_state: assert property (soft_rst |=> (node_addr == ADDR_ZERO) && !addr_assigned
		&& o_alert_south && (alert_status == ALERT_RST))
		else $error("reset command did not restore address state");
	a_addr_copy: assert property (wr_addr && !soft_rst |=> addr_assigned
		&& dev_status[DS_AR] && !alert_status[AS_ADDR_REQ])
		else $error("address write did not set assigned bit");
	a_alert_release: assert property (addr_assigned && (alert_status == 8'h00)
		&& !sy2[SY_ALERT] |-> !o_alert_south)
		else $error("attention held after address assignment");
	a_crc_latch: assert property (crc_fail && !soft_rst |=> o_fault [*2])
		else $error("crc failure not latched on fault output");
	a_crc_discard: assert property (crc_fail |-> !wr_fire)
		else $error("write committed despite bad crc");
	a_locked_cfg: assert property (wr_fire && !unlock && !load_pending
		&& !soft_rst |=> $stable(cfg_flat))
		else $error("protected register written without unlock");
	a_reload_value: assert property (load_pending |=> cfg_flat == $past(dec_flat))
		else $error("protected registers not reloaded from otp");
	a_ecc_alert: assert property (load_pending && any_err && !soft_rst
		|=> alert_status[AS_ECC_ERR] && alert_status[AS_I_FAULT] && o_alert_south)
		else $error("uncorrectable error not reported");
	a_corrected_error_flag: assert property (load_pending && any_cor && !soft_rst |=> corrected_error_flag)
		else $error("corrected error flag not set");
	a_otp_monotone: assert property (!i_otp_upset |=> (otp_mem & $past(otp_mem))
		== $past(otp_mem))
		else $error("otp bit went from one to zero");
	a_parity_flag: assert property ((|par_bad) && !soft_rst |=> alert_status[AS_PARITY])
		else $error("parity mismatch not flagged");

	c_addr_write: cover property (wr_addr);
	c_crc_fail: cover property (crc_fail);
	c_reload: cover property (wr_gate && (hdr_data == GATE_RELOAD));
	c_read: cover property ((state == PK_READ) && byte_done);
endmodule
`default_nettype wire

/* File: sim/sacr_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sacr_host_model (
	input wire logic i_sdo,
	input wire logic i_cs_north,
	output logic o_cs,
	output logic o_sclk,
	output logic o_sdi,
	output logic o_sdo_north
);
	logic [7:0] rd_byte;
	logic csn_seen;
	initial begin
		o_cs = 1'b0;
		o_sclk = 1'b0;
		o_sdi = 1'b0;
		o_sdo_north = 1'b0;
		rd_byte = 8'h00;
		csn_seen = 1'b0;
	end
	// the node above is never addressed, so its released data line toggles rather than holds
	always #100 o_sdo_north = ~o_sdo_north;
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
	// data changes while the serial clock is low, both sides take it at the rise
	task automatic xfer(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			o_sdi = b[i];
			#400;
			o_sclk = 1'b1;
			rd_byte = {rd_byte[6:0], i_sdo};
			#400;
			o_sclk = 1'b0;
		end
	endtask
	// odd offset keeps the serial clock out of phase with the system clock
	task automatic frame_on();
		#37;
		o_cs = 1'b1;
		#800;
	endtask
	// gap after the frame exceeds the four clocks the node needs between frames
	task automatic frame_off();
		#400;
		csn_seen = i_cs_north;
		o_cs = 1'b0;
		o_sdi = ~o_sdi;
		#1000;
	endtask
	// one register per frame, data bits the register ignores sent as the caller gives them (8'h85 sets bit 7)
	task automatic wr(input logic [5:0] a, input logic [7:0] off, input logic [7:0] d,
		input logic bad);
		logic [7:0] c;
		c = crc8(crc8(crc8(8'h00, {1'b0, a, 1'b1}), off), d);
		frame_on();
		xfer({1'b0, a, 1'b1});
		xfer(off);
		xfer(d);
		xfer(c ^ {7'h00, bad});
		frame_off();
	endtask
	task automatic rd(input logic [5:0] a, input logic [7:0] off);
		frame_on();
		xfer({1'b0, a, 1'b0});
		xfer(off);
		xfer(8'h01);
		xfer(8'h00);
		frame_off();
	endtask
endmodule
`default_nettype wire

/* File: sim/sacr_node_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sacr_node_tb_top
	import sacr_pkg::*;
;
	`define CHK(g, e) begin \
		cmp_count++; \
		if ((g) !== (e)) begin \
			num_errors++; \
			$display("wrong value at %0t: got %h expected %h", $time, g, e); \
		end \
	end
	typedef struct packed {
		logic [5:0] tgt;
		logic [7:0] off;
		logic [7:0] data;
		logic [7:0] roff;
		logic [7:0] exp;
	} sacr_row_t;
	sacr_row_t rows [10] = '{
		'{6'h05, 8'h21, 8'h08, 8'h00, 8'h40},
		'{6'h05, 8'h3a, 8'h35, 8'h3a, 8'h35},
		'{6'h05, 8'h40, 8'h5a, 8'h40, 8'h5a},
		'{6'h05, 8'h41, 8'h77, 8'h41, 8'h00},
		'{6'h3f, 8'h3a, 8'h35, 8'h3a, 8'h35},
		'{6'h07, 8'h40, 8'h11, 8'h40, 8'h5a},
		'{6'h05, 8'h3a, 8'h27, 8'h40, 8'h00},
		'{6'h05, 8'h3a, 8'h00, 8'h13, 8'h00},
		'{6'h05, 8'h3a, 8'h35, 8'h3a, 8'h35},
		'{6'h05, 8'h48, 8'h11, 8'h48, 8'h00}
	};
	logic clk = 1'b0;
	logic rst, alert_north, prog, upset;
	logic [7:0] upset_sel;
	wire logic cs_s, sclk_s, sdi_s, sdo_s, cs_n, sdo_n, alert_s, fault, assigned;
	wire logic sclk_n, sdi_n;
	wire logic [5:0] naddr;
	int num_errors = 0;
	int cmp_count = 0;
	always #50 clk = ~clk;
	sacr_node u_dut (
		.i_clk(clk),
		.i_rst(rst),
		.i_cs_south(cs_s),
		.i_sclk_south(sclk_s),
		.i_sdi_south(sdi_s),
		.o_sdo_south(sdo_s),
		.o_cs_north(cs_n),
		.o_sclk_north(sclk_n),
		.o_sdi_north(sdi_n),
		.i_sdo_north(sdo_n),
		.i_alert_north(alert_north),
		.o_alert_south(alert_s),
		.o_fault(fault),
		.i_prog_supply(prog),
		.i_otp_upset(upset),
		.i_otp_upset_sel(upset_sel),
		.o_node_addr(naddr),
		.o_addr_assigned(assigned)
	);
	sacr_host_model u_host (
		.i_sdo(sdo_s),
		.i_cs_north(cs_n),
		.o_cs(cs_s),
		.o_sclk(sclk_s),
		.o_sdi(sdi_s),
		.o_sdo_north(sdo_n)
	);
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask
	task automatic pulse_upset(input logic [7:0] sel);
		upset_sel = sel;
		upset = 1'b1;
		tick(1);
		upset = 1'b0;
	endtask
	task automatic print_verdict();
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// 36 frames of roughly 28 us each; three times that before giving up
	initial begin
		#3_000_000;
		num_errors++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		alert_north = 1'b1;
		prog = 1'b0;
		upset = 1'b0;
		upset_sel = 8'h00;
		tick(20);
		rst = 1'b0;
		tick(2);
		`CHK(naddr, 6'h00)
		`CHK(assigned, 1'b0)
		`CHK(alert_s, 1'b1)
		u_host.wr(ADDR_ZERO, OFF_ADDR_CTRL, 8'h85, 1'b0);
		`CHK(u_host.csn_seen, 1'b0)
		`CHK(naddr, 6'h05)
		`CHK(assigned, 1'b1)
		`CHK(alert_s, 1'b1)
		`CHK(sclk_n, 1'b0)
		`CHK(sdi_n, sdi_s)
		alert_north = 1'b0;
		tick(6);
		`CHK(alert_s, 1'b0)
		foreach (rows[i]) begin
			u_host.wr(rows[i].tgt, rows[i].off, rows[i].data, 1'b0);
			u_host.rd(6'h05, rows[i].roff);
			`CHK(u_host.rd_byte, rows[i].exp)
		end
		`CHK(u_host.csn_seen, 1'b1)
		// a corrupted check byte must leave the address alone
		u_host.wr(6'h05, OFF_ADDR_CTRL, 8'h86, 1'b1);
		`CHK(naddr, 6'h05)
		`CHK(fault, 1'b1)
		u_host.rd(6'h05, OFF_FAULT_STATUS);
		`CHK(u_host.rd_byte, 8'h01)
		`CHK(fault, 1'b1)
		u_host.wr(6'h05, OFF_FAULT_STATUS, 8'h01, 1'b0);
		`CHK(fault, 1'b0)
		u_host.wr(6'h05, OFF_GATE, GATE_UNLOCK, 1'b0);
		u_host.wr(6'h05, OFF_CFG_BASE, 8'h5a, 1'b0);
		prog = 1'b1;
		tick(4);
		u_host.wr(6'h05, OFF_BURN, BURN_CMD, 1'b0);
		prog = 1'b0;
		u_host.wr(6'h05, OFF_RESET, RESET_CMD, 1'b0);
		`CHK(naddr, 6'h00)
		`CHK(assigned, 1'b0)
		`CHK(alert_s, 1'b1)
		u_host.wr(ADDR_ZERO, OFF_ADDR_CTRL, 8'h85, 1'b0);
		u_host.rd(6'h05, OFF_CFG_BASE);
		`CHK(u_host.rd_byte, 8'h5a)
		u_host.rd(6'h05, OFF_FAULT_STATUS);
		`CHK(u_host.rd_byte, 8'h08)
		// one flipped cell is corrected on reload, a second one is not
		pulse_upset(8'h00);
		u_host.wr(6'h05, OFF_GATE, GATE_RELOAD, 1'b0);
		u_host.rd(6'h05, OFF_CFG_BASE);
		`CHK(u_host.rd_byte, 8'h5a)
		u_host.rd(6'h05, OFF_DEV_STATUS);
		`CHK(u_host.rd_byte, 8'h58)
		pulse_upset(8'h01);
		u_host.wr(6'h05, OFF_GATE, GATE_RELOAD, 1'b0);
		`CHK(alert_s, 1'b1)
		u_host.rd(6'h05, OFF_ALERT_STATUS);
		`CHK(u_host.rd_byte, 8'h30)
		print_verdict();
	end
endmodule
`default_nettype wire
